// ---- logic/epm_core.sv ----
// enclave perfmon suppression and record pointer logic
`timescale 1ns/1ps

// Summary of operation
// - status bit sixty reports side-channel interference; clear means normal counting.
// - opt-in entry leaves counting and records normal, flag clear.
// - opt-out entry stops fixed zero and general counters; fixed one, two run.
// - opt-out execution suppresses precise records and sets interference flag.
// - sibling all-threads counters are demoted to own thread during opt-out.
// - exit leaf or asynchronous exit unsuppresses counting and records.
// - demoted sibling counters return to all-threads counting when SIB_OPT_OUT clears.
// - system leaves and key/report leaves report their own instruction address unless suppressed.
// - enter/resume report own address when opt-in, no record when opt-out.
// - record at exit end uses exit address or last entry address.
// - record at async exit end uses saved-state pointer or last entry address.
// - second record after exiting event delivery reports async exit pointer.
// - store faults outside async exit window are delivered now, record skipped.
// - fault on record store at async exit end is hidden, record aborted.
// - trap on record store at async exit end pends to next boundary.
// - after abort the exiting event delivery continues.
// - opt-in transitions count as one far branch and one instruction each.
// - opt-out enclave run counts as one branch and one instruction.
// - counters shared between cores are never affected by entry.
module epm_core #(
	parameter int NUM_GP = epm_pkg::NUM_GP_DEF
) (
	// clock and reset
	input  wire logic                            MCLK,
	input  wire logic                            RSTN,
	input  wire logic                            CE,
	// retirement events
	input  wire epm_pkg::epm_retire_t            RETIRE,
	// record store status
	input  wire logic                            STORE_FAULT,
	input  wire logic                            STORE_TRAP,
	input  wire logic                            INSN_BOUNDARY,
	// counter enables requested by software
	input  wire logic [epm_pkg::NUM_FIXED-1:0]   FIXED_EN,
	input  wire logic [NUM_GP-1:0]               GP_EN,
	input  wire logic [epm_pkg::NUM_FIXED+NUM_GP-1:0] SIB_ANY_CFG,
	input  wire logic                            SIB_OPT_OUT,
	input  wire logic                            RECORD_CFG,
	input  wire logic                            SHARED_EN_IN,
	// gated outputs
	output logic [epm_pkg::NUM_FIXED-1:0]        FIXED_GATE,
	output logic [NUM_GP-1:0]                    GP_GATE,
	output logic [epm_pkg::NUM_FIXED+NUM_GP-1:0] SIB_ANY_EFF,
	output logic                                 SHARED_EN,
	output logic [epm_pkg::STATUS_W-1:0]         GLOBAL_STATUS,
	output epm_pkg::epm_record_t                 RECORD,
	output logic [7:0]                           BRANCH_INC,
	output logic [7:0]                           INSN_INC,
	output logic                                 DELIVER_FAULT,
	output logic                                 TRAP_PENDING,
	output logic                                 RECORD_ABORT,
	output logic                                 SUPPRESSED
);
	epm_pkg::epm_state_t s_q;
	epm_pkg::epm_state_t s_d;

	function automatic logic is_entry(input epm_pkg::epm_ev_t k);
		return k == epm_pkg::EPM_EV_ENTER || k == epm_pkg::EPM_EV_RESUME;
	endfunction

	function automatic logic is_exit(input epm_pkg::epm_ev_t k);
		return k == epm_pkg::EPM_EV_EXIT || k == epm_pkg::EPM_EV_AEX;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.rec = '0;
		s_d.branch_inc = '0;
		s_d.insn_inc = '0;
		s_d.deliver_fault = 1'b0;
		s_d.abort = 1'b0;
		// record store faults outside the exit window
		if (STORE_FAULT && !s_q.in_aex_window) begin
			s_d.deliver_fault = 1'b1;
		end
		if (s_q.in_aex_window) begin
			if (STORE_FAULT) begin
				s_d.abort = 1'b1;
			end
			if (STORE_TRAP) begin
				s_d.trap_pend = 1'b1;
			end
		end
		if (INSN_BOUNDARY && !(s_q.in_aex_window && STORE_TRAP)) begin
			s_d.trap_pend = 1'b0;
		end
		if (RETIRE.valid) begin
			case (RETIRE.kind)
			epm_pkg::EPM_EV_ENTER, epm_pkg::EPM_EV_RESUME: begin
				s_d.entry_addr = RETIRE.insn_addr;
				if (RETIRE.opt_out) begin
					s_d.suppress = 1'b1;
					s_d.sci_flag = 1'b1;
				end else begin
					s_d.suppress = 1'b0;
					s_d.sci_flag = 1'b0;
					s_d.branch_inc = epm_pkg::ONE_INC;
					s_d.insn_inc = epm_pkg::ONE_INC;
					if (RETIRE.record_pending && RECORD_CFG) begin
						s_d.rec.valid = 1'b1;
						s_d.rec.event_ip = RETIRE.insn_addr;
					end
				end
			end
			epm_pkg::EPM_EV_EXIT: begin
				s_d.suppress = 1'b0;
				s_d.sci_flag = 1'b0;
				s_d.branch_inc = epm_pkg::ONE_INC;
				s_d.insn_inc = epm_pkg::ONE_INC;
				if (RETIRE.record_pending && RECORD_CFG) begin
					s_d.rec.valid = 1'b1;
					s_d.rec.event_ip = s_q.suppress ? s_q.entry_addr
						: RETIRE.insn_addr;
				end
			end
			epm_pkg::EPM_EV_AEX: begin
				s_d.suppress = 1'b0;
				s_d.sci_flag = 1'b0;
				s_d.branch_inc = epm_pkg::ONE_INC;
				s_d.insn_inc = epm_pkg::ONE_INC;
				s_d.in_aex_window = 1'b1;
				if (RETIRE.record_pending && RECORD_CFG) begin
					s_d.rec.valid = 1'b1;
					s_d.rec.synthetic = 1'b1;
					s_d.rec.event_ip = s_q.suppress ? s_q.entry_addr
						: RETIRE.ssa_addr;
				end
			end
			epm_pkg::EPM_EV_SYS_LEAF, epm_pkg::EPM_EV_KEYRPT_LEAF: begin
				if (RETIRE.record_pending && RECORD_CFG && !s_q.suppress) begin
					s_d.rec.valid = 1'b1;
					s_d.rec.event_ip = RETIRE.insn_addr;
				end
			end
			epm_pkg::EPM_EV_EEE_DONE: begin
				// exiting event delivery goes on even after abort
				s_d.in_aex_window = 1'b0;
				if (RETIRE.record_pending && RECORD_CFG) begin
					s_d.rec.valid = 1'b1;
					s_d.rec.event_ip = RETIRE.aep_addr;
				end
			end
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '0;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	always_comb begin
		FIXED_GATE = FIXED_EN;
		FIXED_GATE[0] = FIXED_EN[0] & ~s_q.suppress;
		GP_GATE = GP_EN & {NUM_GP{~s_q.suppress}};
		SIB_ANY_EFF = SIB_ANY_CFG
			& {(epm_pkg::NUM_FIXED+NUM_GP){~SIB_OPT_OUT}};
		SHARED_EN = SHARED_EN_IN;
		GLOBAL_STATUS = '0;
		GLOBAL_STATUS[epm_pkg::SCI_BIT] = s_q.sci_flag;
		RECORD = s_q.rec;
		RECORD.valid = s_q.rec.valid & ~s_q.abort;
		BRANCH_INC = s_q.branch_inc;
		INSN_INC = s_q.insn_inc;
		DELIVER_FAULT = s_q.deliver_fault;
		TRAP_PENDING = s_q.trap_pend;
		RECORD_ABORT = s_q.abort;
		SUPPRESSED = s_q.suppress;
	end
endmodule

// ---- shared/epm_pkg.sv ----
// shared types and constants for enclave perfmon suppression
package epm_pkg;
	localparam int ADDR_W         = 64;
	localparam int STATUS_W       = 64;
	localparam int SCI_BIT        = 60;
	localparam int NUM_GP_DEF     = 4;
	localparam int NUM_FIXED      = 3;
	localparam logic RST_FLAG     = 1'b0;
	localparam logic [7:0] ONE_INC = 8'h01;

	// enclave transition kinds from retirement
	typedef enum logic [2:0] {
		EPM_EV_NONE,
		EPM_EV_ENTER,
		EPM_EV_RESUME,
		EPM_EV_EXIT,
		EPM_EV_AEX,
		EPM_EV_SYS_LEAF,
		EPM_EV_KEYRPT_LEAF,
		EPM_EV_EEE_DONE
	} epm_ev_t;

	// one retirement event from the core
	typedef struct packed {
		logic               valid;
		epm_ev_t            kind;
		logic               opt_out;
		logic [ADDR_W-1:0]  insn_addr;
		logic [ADDR_W-1:0]  ssa_addr;
		logic [ADDR_W-1:0]  aep_addr;
		logic               record_pending;
	} epm_retire_t;

	// record request to the store engine
	typedef struct packed {
		logic               valid;
		logic [ADDR_W-1:0]  event_ip;
		logic               synthetic;
	} epm_record_t;

	// block state
	typedef struct packed {
		logic               suppress;
		logic               sci_flag;
		logic [ADDR_W-1:0]  entry_addr;
		logic               in_aex_window;
		logic               second_pend;
		logic               trap_pend;
		logic               abort;
		epm_record_t        rec;
		logic [7:0]         branch_inc;
		logic [7:0]         insn_inc;
		logic               deliver_fault;
	} epm_state_t;
endpackage

// ---- verification/epm_core_props.sv ----
// assertion checker for enclave perfmon suppression ports
`timescale 1ns/1ps
module epm_core_props #(parameter int NUM_GP = 4) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire epm_pkg::epm_retire_t RETIRE,
	input wire logic [2:0] FIXED_EN,
	input wire logic [2:0] FIXED_GATE,
	input wire logic [NUM_GP+2:0] SIB_ANY_CFG,
	input wire logic SIB_OPT_OUT,
	input wire logic [NUM_GP+2:0] SIB_ANY_EFF,
	input wire logic [63:0] GLOBAL_STATUS,
	input wire epm_pkg::epm_record_t RECORD,
	input wire logic RECORD_ABORT,
	input wire logic SUPPRESSED
);
	wire logic go = CE && RETIRE.valid;
	wire logic ent = go && RETIRE.kind inside {epm_pkg::EPM_EV_ENTER,
		epm_pkg::EPM_EV_RESUME};
	wire logic ext = go && RETIRE.kind inside {epm_pkg::EPM_EV_EXIT,
		epm_pkg::EPM_EV_AEX};
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	AST_FIX0_OFF: assert property (SUPPRESSED |-> !FIXED_GATE[0])
		else $error("fixed counter zero runs while suppressed");
	AST_CYC_RUN: assert property (FIXED_GATE[2:1] == FIXED_EN[2:1])
		else $error("cycle counters gated");
	AST_STATUS: assert property (GLOBAL_STATUS == {3'h0, SUPPRESSED, 60'h0})
		else $error("status flag wrong");
	AST_OUT_IN: assert property (ent && RETIRE.opt_out |=> SUPPRESSED && !RECORD.valid)
		else $error("opt-out entry not suppressed");
	AST_IN_IN: assert property (ent && !RETIRE.opt_out && !SUPPRESSED |=> !SUPPRESSED)
		else $error("opt-in entry suppressed");
	AST_EXIT: assert property (ext |=> !SUPPRESSED)
		else $error("exit left suppression on");
	AST_SIB: assert property (SIB_ANY_EFF == (SIB_OPT_OUT ? '0 : SIB_ANY_CFG))
		else $error("sibling demotion wrong");
	AST_ABORT: assert property (RECORD_ABORT |-> !RECORD.valid)
		else $error("record sent with abort");
endmodule
bind epm_core epm_core_props #(.NUM_GP(NUM_GP)) u_props (.MCLK(MCLK),
	.RSTN(RSTN), .CE(CE), .RETIRE(RETIRE), .FIXED_EN(FIXED_EN),
	.FIXED_GATE(FIXED_GATE), .SIB_ANY_CFG(SIB_ANY_CFG),
	.SIB_OPT_OUT(SIB_OPT_OUT), .SIB_ANY_EFF(SIB_ANY_EFF),
	.GLOBAL_STATUS(GLOBAL_STATUS), .RECORD(RECORD),
	.RECORD_ABORT(RECORD_ABORT), .SUPPRESSED(SUPPRESSED));

// ---- verification/epm_core_tb.sv ----
// self-checking bench for enclave perfmon suppression
`timescale 1ns/1ps
module epm_core_tb;
	logic MCLK = 0, RSTN = 0, CE = 1, SIB_OPT_OUT = 0, SHARED_EN_IN = 1;
	logic STORE_FAULT = 0, STORE_TRAP = 0, INSN_BOUNDARY = 0;
	logic [2:0] FIXED_GATE;
	logic [3:0] GP_GATE;
	logic [6:0] SIB_ANY_EFF;
	logic [63:0] GLOBAL_STATUS;
	logic [7:0] BRANCH_INC, INSN_INC;
	logic SHARED_EN, DELIVER_FAULT, TRAP_PENDING, RECORD_ABORT, SUPPRESSED;
	epm_pkg::epm_retire_t RETIRE;
	epm_pkg::epm_record_t RECORD;
	int error_cnt = 0, checked = 0, cyc = 0;
	epm_retire_model mdl (.MCLK(MCLK), .RETIRE(RETIRE));
	epm_core u_dut (.MCLK(MCLK), .RSTN(RSTN), .CE(CE), .RETIRE(RETIRE),
		.STORE_FAULT(STORE_FAULT), .STORE_TRAP(STORE_TRAP),
		.INSN_BOUNDARY(INSN_BOUNDARY), .FIXED_EN(3'h7), .GP_EN(4'hF),
		.SIB_ANY_CFG(7'h7F), .SIB_OPT_OUT(SIB_OPT_OUT), .RECORD_CFG(1'b1),
		.SHARED_EN_IN(SHARED_EN_IN), .FIXED_GATE(FIXED_GATE),
		.GP_GATE(GP_GATE), .SIB_ANY_EFF(SIB_ANY_EFF), .SHARED_EN(SHARED_EN),
		.GLOBAL_STATUS(GLOBAL_STATUS), .RECORD(RECORD),
		.BRANCH_INC(BRANCH_INC), .INSN_INC(INSN_INC),
		.DELIVER_FAULT(DELIVER_FAULT), .TRAP_PENDING(TRAP_PENDING),
		.RECORD_ABORT(RECORD_ABORT), .SUPPRESSED(SUPPRESSED));
	always #5 MCLK = ~MCLK;
	task chk(input logic [79:0] got, input logic [79:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge MCLK);
		#1;
	endtask
	task t_optin;
		mdl.send(epm_pkg::EPM_EV_SYS_LEAF, 1'b0, 64'h800, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h800});
		mdl.send(epm_pkg::EPM_EV_KEYRPT_LEAF, 1'b0, 64'h900, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h900});
		mdl.send(epm_pkg::EPM_EV_ENTER, 1'b0, 64'h1000, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h1000});
		chk({SUPPRESSED, GLOBAL_STATUS}, 0);
		mdl.send(epm_pkg::EPM_EV_EXIT, 1'b0, 64'h2000, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h2000});
		chk({BRANCH_INC, INSN_INC}, 16'h0101);
		$display("optin test done");
	endtask
	task t_optout;
		mdl.send(epm_pkg::EPM_EV_RESUME, 1'b1, 64'h3000, 1'b1);
		chk({RECORD.valid, SUPPRESSED, GLOBAL_STATUS},
			{2'h1, 64'h1000000000000000});
		chk({FIXED_GATE, GP_GATE}, 7'h60);
		SIB_OPT_OUT = 1;
		SHARED_EN_IN = 0;
		#1 chk({SIB_ANY_EFF, SHARED_EN}, 0);
		SIB_OPT_OUT = 0;
		#1 chk(SIB_ANY_EFF, 7'h7F);
		mdl.send(epm_pkg::EPM_EV_EXIT, 1'b0, 64'h4000, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h3000});
		chk({SUPPRESSED, BRANCH_INC, INSN_INC}, 17'h0101);
		$display("optout test done");
	endtask
	task t_aex;
		mdl.send(epm_pkg::EPM_EV_ENTER, 1'b0, 64'h5000, 1'b0);
		mdl.send(epm_pkg::EPM_EV_AEX, 1'b0, 64'h6000, 1'b1);
		chk({RECORD.valid, RECORD.event_ip, RECORD.synthetic},
			{1'b1, 64'h6001, 1'b1});
		STORE_FAULT = 1;
		step;
		STORE_FAULT = 0;
		chk({RECORD_ABORT, DELIVER_FAULT}, 2'h2);
		STORE_TRAP = 1;
		step;
		STORE_TRAP = 0;
		chk(TRAP_PENDING, 1'b1);
		mdl.send(epm_pkg::EPM_EV_EEE_DONE, 1'b0, 64'h7000, 1'b1);
		chk({RECORD.valid, RECORD.event_ip}, {1'b1, 64'h7002});
		INSN_BOUNDARY = 1;
		step;
		INSN_BOUNDARY = 0;
		chk(TRAP_PENDING, 1'b0);
		STORE_FAULT = 1;
		step;
		STORE_FAULT = 0;
		chk({DELIVER_FAULT, RECORD.valid}, 2'h2);
		$display("async exit test done");
	endtask
	task t_ce;
		CE = 0;
		mdl.send(epm_pkg::EPM_EV_ENTER, 1'b1, 64'h8000, 1'b1);
		chk({SUPPRESSED, BRANCH_INC, RECORD.valid}, 0);
		CE = 1;
		mdl.send(epm_pkg::EPM_EV_ENTER, 1'b1, 64'h8000, 1'b1);
		chk({SUPPRESSED, GLOBAL_STATUS[60]}, 2'h3);
		mdl.send(epm_pkg::EPM_EV_AEX, 1'b0, 64'h9000, 1'b1);
		chk({SUPPRESSED, RECORD.valid, RECORD.event_ip},
			{2'h1, 64'h8000});
		$display("clock enable test done");
	endtask
	task wrap_up;
		$display("checks=%0d errors=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 500) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		repeat (5) @(posedge MCLK);
		#1 RSTN = 1;
		t_optin;
		t_optout;
		t_aex;
		t_ce;
		wrap_up;
	end
endmodule

// ---- verification/epm_retire_model.sv ----
// retirement-side model issuing enclave transition events
`timescale 1ns/1ps
module epm_retire_model (
	input wire logic MCLK,
	output epm_pkg::epm_retire_t RETIRE
);
	initial RETIRE = '0;
	// one event a call; fields scrambled once released
	task automatic send(input epm_pkg::epm_ev_t k, input logic oo,
		input logic [63:0] a, input logic p);
		// idle edge keeps back-to-back calls from rewriting in one step
		@(posedge MCLK);
		#1 RETIRE = '{1'b1, k, oo, a, a + 64'h1, a + 64'h2, p};
		@(posedge MCLK);
		#1 RETIRE = {1'b0, ~RETIRE[$bits(RETIRE)-2:0]};
	endtask
endmodule
